//--- rtl/interrupt_vector_resolver.sv
// module: interrupt vector resolver, request latching, arbitration, vector fetch
// assumes a cpu sequencer and an 8-bit vector memory port on mclk_in
//
// Notes on behaviour
// RULE1: address match enabled raises interrupt before instruction
// RULE2: match only on instruction first byte
// RULE3: peripherals share software numbers 4 to 31
// RULE4: peripheral sources gated by enable and priority
// RULE5: low key pin level requests key interrupt
// RULE6: edge pins fire on chosen edge polarity
// RULE7: fixed vectors sit in top region
// RULE8: every vector entry is four bytes
// RULE9: trap, overflow, break fixed addresses
// RULE10: address match, single step, debugger addresses
// RULE11: watchdog, nmi and reset fixed addresses
// RULE12: empty break vector redirects to table entry
// RULE13: variable table is 256 bytes at base
// RULE14: entry n sits at base plus 4n
// RULE15: numbers 0 and 32-63 never masked
// RULE16: slots 4 to 14 source order
// RULE17: slots 15 to 20 serial order
// RULE18: slots 21 to 31 timers then pins
// RULE19: cause bits 6,7 choose shared slots
// RULE20: i2c mode puts nack/ack in uart2 slots
// RULE21: accept needs enable, request, level above threshold
// RULE22: request set by source, cleared on accept
// RULE23: entry read little-endian, low byte first
`timescale 1ns/100ps
module interrupt_vector_resolver (
  input  wire logic              mclk_in,
  input  wire logic              srst_in,
  input  wire vec_pkg::raddr_t   reg_addr_in,
  input  wire logic [7:0]        reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic [7:0]             reg_rdata_out,
  input  wire logic [31:0]       periph_evt_in,
  input  wire logic              uart2_nack_in,
  input  wire logic              uart2_ack_in,
  input  wire logic [5:0]        ext_edge_irq_in,
  input  wire logic              key_input_pin_n_in,
  input  wire logic              i_flag_in,
  input  wire logic [2:0]        processor_priority_threshold_in,
  input  wire logic              instr_start_in,
  input  wire vec_pkg::addr_t    instr_addr_in,
  output logic                   addr_match_req_out,
  output logic                   irq_pending_out,
  output logic [5:0]             irq_num_out,
  output logic [2:0]             irq_level_out,
  input  wire logic              vec_req_in,
  input  wire vec_pkg::vec_src_e vec_src_in,
  input  wire logic [5:0]        vec_num_in,
  input  wire logic              vec_hw_in,
  output logic                   mem_rd_out,
  output vec_pkg::addr_t         mem_addr_out,
  input  wire logic [7:0]        mem_rdata_in,
  input  wire logic              mem_ack_in,
  output logic                   vec_done_out,
  output vec_pkg::addr_t         handler_addr_out
);
  import vec_pkg::*;

  // ==========================================================
  // state and storage
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_FETCH = 3'h2,
    ST_CHECK = 3'h4
  } fetch_state_e;

  fetch_state_e state_ff;
  addr_t        am_addr_ff;
  logic         am_en_ff;
  addr_t        vb_ff;
  logic         i2c_ff;
  logic [11:0]  pol_ff;
  logic [1:0]   cause_ff;
  logic [31:0]  req_ff;
  logic [2:0]   lvl_ff [32];
  logic [7:0]   rdata_ff;
  logic         am_hit_ff;
  logic         pend_ff;
  logic [5:0]   pnum_ff;
  logic [2:0]   plvl_ff;
  logic         mem_rd_ff;
  addr_t        mem_addr_ff;
  logic [1:0]   idx_ff;
  logic [31:0]  entry_ff;
  logic         is_brk_ff;
  logic         done_ff;
  addr_t        handler_ff;

  // ==========================================================
  // pin synchronisers
  logic [6:0] pin_lvl;
  logic [6:0] pin_edge;
  wire  [6:0] pins = {key_input_pin_n_in, ext_edge_irq_in};
  wire  [13:0] pols = {2'h0, pol_ff};

  for (genvar p = 0; p < 7; p++) begin : g_pin
    pin_edge_sync u_sync (
      .mclk_in   (mclk_in),
      .srst_in   (srst_in),
      .pin_in    (pins[p]),
      .pol_in    (pols[2*p +: 2]),
      .level_out (pin_lvl[p]),
      .edge_out  (pin_edge[p])
    );
  end

  // ==========================================================
  // source to slot mapping
  logic [31:0] src_evt;
  always_comb begin
    src_evt = periph_evt_in & HW_SLOT_MASK;                          // RULE3
    src_evt[SLOT_EXT3] = pin_edge[3];                                 // RULE16
    src_evt[SLOT_SIO4] = cause_ff[0] ? pin_edge[5] : periph_evt_in[SLOT_SIO4]; // RULE19
    src_evt[SLOT_SIO3] = cause_ff[1] ? pin_edge[4] : periph_evt_in[SLOT_SIO3]; // RULE19
    src_evt[SLOT_KEY]  = !pin_lvl[6];                                 // RULE5
    src_evt[SLOT_U2TX] = i2c_ff ? uart2_nack_in : periph_evt_in[SLOT_U2TX]; // RULE20
    src_evt[SLOT_U2RX] = i2c_ff ? uart2_ack_in : periph_evt_in[SLOT_U2RX];  // RULE17
    src_evt[SLOT_EXT0 +: 3] = pin_edge[2:0];                          // RULE18
  end

  // ==========================================================
  // register decode
  function automatic logic is_icr(input raddr_t a);
    is_icr = a[RADDR_W-1:5] == REG_ICR_BASE[RADDR_W-1:5];
  endfunction

  wire       icr_wr  = reg_wr_in && is_icr(reg_addr_in);
  wire [4:0] icr_idx = reg_addr_in[4:0];
  wire [7:0] icr_rd  = {4'h0, req_ff[icr_idx], lvl_ff[icr_idx]};
  wire [7:0] rd_mux  =
    is_icr(reg_addr_in)       ? icr_rd :
    (reg_addr_in == REG_AM0)  ? am_addr_ff[7:0] :
    (reg_addr_in == REG_AM1)  ? am_addr_ff[15:8] :
    (reg_addr_in == REG_AM2)  ? {4'h0, am_addr_ff[19:16]} :
    (reg_addr_in == REG_AM_EN)? {7'h00, am_en_ff} :
    (reg_addr_in == REG_VB0)  ? vb_ff[7:0] :
    (reg_addr_in == REG_VB1)  ? vb_ff[15:8] :
    (reg_addr_in == REG_VB2)  ? {4'h0, vb_ff[19:16]} :
    (reg_addr_in == REG_MODE) ? {7'h00, i2c_ff} :
    (reg_addr_in == REG_POL0) ? pol_ff[7:0] :
    (reg_addr_in == REG_POL1) ? {4'h0, pol_ff[11:8]} :
    (reg_addr_in == REG_CAUSE)? {cause_ff, 6'h00} : 8'h00;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      am_addr_ff <= '0;
      am_en_ff   <= 1'b0;
      vb_ff      <= '0;
      i2c_ff     <= 1'b0;
      pol_ff     <= '0;
      cause_ff   <= 2'h0;
      rdata_ff   <= RST_BYTE;
    end else begin
      rdata_ff <= reg_rd_in ? rd_mux : RST_BYTE;
      if (reg_wr_in) begin
        case (reg_addr_in)
          REG_AM0:   am_addr_ff[7:0]   <= reg_wdata_in;
          REG_AM1:   am_addr_ff[15:8]  <= reg_wdata_in;
          REG_AM2:   am_addr_ff[19:16] <= reg_wdata_in[3:0];
          REG_AM_EN: am_en_ff          <= reg_wdata_in[0];
          REG_VB0:   vb_ff[7:0]        <= reg_wdata_in;
          REG_VB1:   vb_ff[15:8]       <= reg_wdata_in;
          REG_VB2:   vb_ff[19:16]      <= reg_wdata_in[3:0];
          REG_MODE:  i2c_ff            <= reg_wdata_in[0];
          REG_POL0:  pol_ff[7:0]       <= reg_wdata_in;
          REG_POL1:  pol_ff[11:8]      <= reg_wdata_in[3:0];
          REG_CAUSE: cause_ff <= {reg_wdata_in[CAUSE_SIO3_BIT], reg_wdata_in[CAUSE_SIO4_BIT]};
          default:   ;
        endcase
      end
    end
  end

  // ==========================================================
  // request bits and levels
  wire take = (state_ff == ST_IDLE) && vec_req_in;
  wire hw_accept = take && vec_hw_in && (vec_src_in == VS_SWINT);
  logic [31:0] nxt_req;

  for (genvar g = 0; g < 32; g++) begin : g_req
    wire sw_clr  = icr_wr && (icr_idx == 5'(g)) && !reg_wdata_in[ICR_REQ_BIT];
    wire acc_clr = hw_accept && (vec_num_in == 6'(g));
    // a source event in the clearing cycle wins
    assign nxt_req[g] = HW_SLOT_MASK[g] &&
                        (src_evt[g] || (req_ff[g] && !sw_clr && !acc_clr)); // RULE22

    always_ff @(posedge mclk_in) begin
      if (srst_in) lvl_ff[g] <= RST_LVL;
      else if (icr_wr && (icr_idx == 5'(g))) lvl_ff[g] <= reg_wdata_in[2:0];
    end
  end

  // ==========================================================
  // arbitration: highest level, lowest number on a tie
  logic       found;
  logic [5:0] best_num;
  logic [2:0] best_lvl;
  always_comb begin
    found    = 1'b0;
    best_num = SWI_HW_LO;
    best_lvl = processor_priority_threshold_in;
    // only slots 4..31 compete; 0 and 32..63 are not gated here
    for (int i = 4; i < 32; i++) begin                                // RULE15
      if (req_ff[i] && (lvl_ff[i] > best_lvl)) begin                  // RULE21
        found    = 1'b1;
        best_num = 6'(i);
        best_lvl = lvl_ff[i];
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      req_ff    <= '0;
      pend_ff   <= 1'b0;
      pnum_ff   <= SWI_BRK;
      plvl_ff   <= RST_LVL;
      am_hit_ff <= 1'b0;
    end else begin
      req_ff    <= nxt_req;
      pend_ff   <= found && i_flag_in;                                 // RULE4
      pnum_ff   <= best_num;
      plvl_ff   <= best_lvl;
      // instr_start_in marks only an instruction's first byte
      am_hit_ff <= instr_start_in && am_en_ff && (instr_addr_in == am_addr_ff); // RULE1 RULE2
    end
  end

  // ==========================================================
  // vector address
  function automatic addr_t fixed_vec(input vec_src_e s);
    case (s)                                                          // RULE7
      VS_UND:   fixed_vec = FIX_UND;                                  // RULE9
      VS_OVF:   fixed_vec = FIX_OVF;
      VS_BRK:   fixed_vec = FIX_BRK;
      VS_ADDRM: fixed_vec = FIX_ADDRM;                                // RULE10
      VS_STEP:  fixed_vec = FIX_STEP;
      VS_DBC:   fixed_vec = FIX_DBC;
      VS_WDT:   fixed_vec = FIX_WDT;                                  // RULE11
      VS_NMI:   fixed_vec = FIX_NMI;
      default:  fixed_vec = FIX_RST;
    endcase
  endfunction

  // 8-bit offset keeps the entry inside the 256-byte table
  wire [7:0] var_off  = {vec_num_in, 2'b00};                          // RULE14
  wire addr_t var_vec = vb_ff + {12'h000, var_off};                   // RULE13
  wire addr_t start   = (vec_src_in == VS_SWINT) ? var_vec : fixed_vec(vec_src_in);
  wire brk_empty      = is_brk_ff && (entry_ff == BRK_EMPTY_ENTRY);

  // ==========================================================
  // vector fetch
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state_ff    <= ST_IDLE;
      mem_rd_ff   <= 1'b0;
      mem_addr_ff <= '0;
      idx_ff      <= 2'h0;
      entry_ff    <= '0;
      is_brk_ff   <= 1'b0;
      done_ff     <= 1'b0;
      handler_ff  <= '0;
    end else begin
      done_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (vec_req_in) begin
            mem_addr_ff <= start;
            mem_rd_ff   <= 1'b1;
            idx_ff      <= 2'h0;
            is_brk_ff   <= vec_src_in == VS_BRK;
            state_ff    <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (mem_ack_in) begin
            entry_ff <= {mem_rdata_in, entry_ff[31:8]};               // RULE23
            if (idx_ff == VEC_LAST_IDX) begin                         // RULE8
              mem_rd_ff <= 1'b0;
              state_ff  <= ST_CHECK;
            end else begin
              idx_ff      <= idx_ff + 2'h1;
              mem_addr_ff <= mem_addr_ff + 20'h00001;
            end
          end
        end
        ST_CHECK: begin
          if (brk_empty) begin                                        // RULE12
            mem_addr_ff <= vb_ff;
            mem_rd_ff   <= 1'b1;
            idx_ff      <= 2'h0;
            is_brk_ff   <= 1'b0;
            state_ff    <= ST_FETCH;
          end else begin
            handler_ff <= entry_ff[ADDR_W-1:0];
            done_ff    <= 1'b1;
            state_ff   <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  assign reg_rdata_out      = rdata_ff;
  assign addr_match_req_out = am_hit_ff;
  assign irq_pending_out    = pend_ff;
  assign irq_num_out        = pnum_ff;
  assign irq_level_out      = plvl_ff;
  assign mem_rd_out         = mem_rd_ff;
  assign mem_addr_out       = mem_addr_ff;
  assign vec_done_out       = done_ff;
  assign handler_addr_out   = handler_ff;

  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  a_match_fires: assert property ( // RULE1
    instr_start_in && am_en_ff && instr_addr_in == am_addr_ff |=> addr_match_req_out)
    else $error("address match not raised");
  a_match_first_byte: assert property ( // RULE2
    addr_match_req_out |-> $past(instr_start_in) && $past(am_en_ff))
    else $error("address match without instruction start");
  a_pend_enable: assert property ( // RULE4
    irq_pending_out |-> $past(i_flag_in))
    else $error("pending while enable flag low");
  a_pend_level: assert property ( // RULE21
    irq_pending_out |-> irq_level_out > $past(processor_priority_threshold_in))
    else $error("pending level not above threshold");
  a_pend_range: assert property ( // RULE3
    irq_pending_out |-> irq_num_out >= 6'h04 && irq_num_out <= 6'h1f)
    else $error("pending number outside peripheral slots");
  a_und_vector: assert property ( // RULE9
    take && vec_src_in == VS_UND |=> mem_rd_out && mem_addr_out == 20'hfffdc)
    else $error("undefined opcode vector address wrong");
  a_addrm_vector: assert property ( // RULE10
    take && vec_src_in == VS_ADDRM |=> mem_addr_out == 20'hfffe8)
    else $error("address match vector address wrong");
  a_reset_vector: assert property ( // RULE11
    take && vec_src_in == VS_RST |=> mem_addr_out == 20'hffffc)
    else $error("reset vector address wrong");
  a_var_vector: assert property ( // RULE14
    take && vec_src_in == VS_SWINT |=>
      mem_addr_out == $past(vb_ff) + {12'h000, $past(vec_num_in), 2'b00})
    else $error("variable vector address wrong");
  a_brk_redirect: assert property ( // RULE12
    state_ff == ST_CHECK && brk_empty |=> mem_rd_out && mem_addr_out == $past(vb_ff))
    else $error("empty break vector not redirected");
  a_accept_clear: assert property ( // RULE22
    hw_accept && vec_num_in == 6'h15 && !src_evt[21] |=> !req_ff[21])
    else $error("request bit not cleared on accept");
  a_key_request: assert property ( // RULE5
    !pin_lvl[6] |=> req_ff[SLOT_KEY])
    else $error("key level did not set request");
  a_done_entry: assert property ( // RULE23
    vec_done_out |-> handler_addr_out == $past(entry_ff[19:0]) && !$past(mem_rd_out))
    else $error("handler address not taken from entry");

  c_fixed_fetch: cover property (take && vec_src_in == VS_NMI ##[1:20] vec_done_out);
  c_brk_redirect: cover property (state_ff == ST_CHECK && brk_empty);
  c_hw_accept: cover property (irq_pending_out ##1 hw_accept);
  c_addr_match: cover property (addr_match_req_out);
endmodule // interrupt_vector_resolver

//--- rtl/pin_edge_sync.sv
// module: three-stage pin synchroniser with polarity-selected edge pulse
// assumes pin_in is asynchronous to mclk_in
`timescale 1ns/100ps
module pin_edge_sync (
  input  wire logic       mclk_in,
  input  wire logic       srst_in,
  input  wire logic       pin_in,
  input  wire logic [1:0] pol_in,
  output logic            level_out,
  output logic            edge_out
);
  import vec_pkg::*;

  logic [2:0] sync_ff;
  logic       lvl_ff;
  logic       edge_ff;
  wire        stable   = sync_ff[1] == sync_ff[2];
  wire        rise     = stable && sync_ff[2] && !lvl_ff;
  wire        fall     = stable && !sync_ff[2] && lvl_ff;
  // rising, falling or both edges by polarity select
  wire        nxt_edge = (pol_in == POL_RISE) ? rise :   // RULE6
                         (pol_in == POL_FALL) ? fall : (rise || fall);

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      sync_ff <= 3'h7;
      lvl_ff  <= 1'b1;
      edge_ff <= 1'b0;
    end else begin
      sync_ff <= {sync_ff[1:0], pin_in};
      if (stable) lvl_ff <= sync_ff[2];
      edge_ff <= nxt_edge;
    end
  end

  assign level_out = lvl_ff;
  assign edge_out  = edge_ff;
endmodule // pin_edge_sync

//--- rtl/vec_pkg.sv
// package: constants, addresses and types of the interrupt vector resolver
// assumes a 20-bit address space and an 8-bit register port
package vec_pkg;
  // ==========================================================
  // widths and types
  localparam int ADDR_W = 20;
  localparam int RADDR_W = 10;
  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [RADDR_W-1:0] raddr_t;

  typedef enum logic [3:0] {
    VS_UND   = 4'h0,
    VS_OVF   = 4'h1,
    VS_BRK   = 4'h2,
    VS_ADDRM = 4'h3,
    VS_STEP  = 4'h4,
    VS_WDT   = 4'h5,
    VS_DBC   = 4'h6,
    VS_NMI   = 4'h7,
    VS_RST   = 4'h8,
    VS_SWINT = 4'h9
  } vec_src_e;

  // ==========================================================
  // fixed vector region
  localparam addr_t FIX_LO    = 20'hfffdc;
  localparam addr_t FIX_HI    = 20'hfffff;
  localparam addr_t FIX_UND   = 20'hfffdc;
  localparam addr_t FIX_OVF   = 20'hfffe0;
  localparam addr_t FIX_BRK   = 20'hfffe4;
  localparam addr_t FIX_ADDRM = 20'hfffe8;
  localparam addr_t FIX_STEP  = 20'hfffec;
  localparam addr_t FIX_WDT   = 20'hffff0;
  localparam addr_t FIX_DBC   = 20'hffff4;
  localparam addr_t FIX_NMI   = 20'hffff8;
  localparam addr_t FIX_RST   = 20'hffffc;

  // ==========================================================
  // vector entries and variable table
  localparam int          VEC_BYTES       = 4;
  localparam logic [1:0]  VEC_LAST_IDX    = 2'(VEC_BYTES - 1);
  localparam int          VAR_TABLE_BYTES = 256;
  localparam logic [31:0] BRK_EMPTY_ENTRY = 32'hffffffff;
  localparam logic [5:0]  SWI_BRK         = 6'h00;
  localparam logic [5:0]  SWI_HW_LO       = 6'h04;
  localparam logic [5:0]  SWI_HW_HI       = 6'h1f;
  localparam logic [31:0] HW_SLOT_MASK    = 32'hfffffff0;

  // ==========================================================
  // shared source slots
  localparam int SLOT_EXT3  = 4;
  localparam int SLOT_SIO4  = 8;
  localparam int SLOT_SIO3  = 9;
  localparam int SLOT_KEY   = 13;
  localparam int SLOT_U2TX  = 15;
  localparam int SLOT_U2RX  = 16;
  localparam int SLOT_EXT0  = 29;
  localparam int CAUSE_SIO4_BIT = 6;
  localparam int CAUSE_SIO3_BIT = 7;

  // ==========================================================
  // register offsets, fields and reset values
  localparam raddr_t REG_AM0      = 10'h010;
  localparam raddr_t REG_AM1      = 10'h011;
  localparam raddr_t REG_AM2      = 10'h012;
  localparam raddr_t REG_AM_EN    = 10'h013;
  localparam raddr_t REG_VB0      = 10'h014;
  localparam raddr_t REG_VB1      = 10'h015;
  localparam raddr_t REG_VB2      = 10'h016;
  localparam raddr_t REG_MODE     = 10'h017;
  localparam raddr_t REG_POL0     = 10'h018;
  localparam raddr_t REG_POL1     = 10'h019;
  localparam raddr_t REG_CAUSE    = 10'h35f;
  localparam raddr_t REG_ICR_BASE = 10'h040;
  localparam int     ICR_REQ_BIT  = 3;
  localparam logic [1:0] POL_FALL = 2'h0;
  localparam logic [1:0] POL_RISE = 2'h1;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_LVL  = 3'h0;
endpackage

//--- sim/interrupt_vector_resolver_tb.sv
// file: self-checking bench of the interrupt vector resolver
// assumes vec_pkg and the vector memory model
`timescale 1ns/100ps
module interrupt_vector_resolver_tb;
  import vec_pkg::*;
  logic       clk, rst, wr, rd, nack, ack2, key_n, iflag, istart, vreq, vhw;
  logic       slow, brk_e, amreq, pend, mrd, mack, done;
  logic [7:0] wdat, rdat, mdat;
  logic [31:0] evt;
  logic [5:0] pins, num, vnum;
  logic [2:0] thr, lvl;
  raddr_t     radr;
  addr_t      iaddr, maddr, haddr;
  vec_src_e   vsrc;
  int         n_mismatch, num_checks, i;
  localparam addr_t VB = 20'h12340;

  interrupt_vector_resolver dut (
    .mclk_in(clk), .srst_in(rst), .reg_addr_in(radr), .reg_wdata_in(wdat),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat), .periph_evt_in(evt),
    .uart2_nack_in(nack), .uart2_ack_in(ack2), .ext_edge_irq_in(pins),
    .key_input_pin_n_in(key_n), .i_flag_in(iflag),
    .processor_priority_threshold_in(thr), .instr_start_in(istart),
    .instr_addr_in(iaddr), .addr_match_req_out(amreq), .irq_pending_out(pend),
    .irq_num_out(num), .irq_level_out(lvl), .vec_req_in(vreq), .vec_src_in(vsrc),
    .vec_num_in(vnum), .vec_hw_in(vhw), .mem_rd_out(mrd), .mem_addr_out(maddr),
    .mem_rdata_in(mdat), .mem_ack_in(mack), .vec_done_out(done),
    .handler_addr_out(haddr));
  vec_mem_model mem (
    .mclk_in(clk), .srst_in(rst), .slow_in(slow), .brk_empty_in(brk_e),
    .mem_rd_in(mrd), .mem_addr_in(maddr), .mem_rdata_out(mdat), .mem_ack_out(mack));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ====
  // shared tasks
  task print_verdict;
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  function automatic addr_t h(addr_t a);
    return {4'(a + 20'h2), 8'(a + 20'h1), a[7:0]};
  endfunction
  task tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wreg(raddr_t a, logic [7:0] d);
    @(posedge clk);
    radr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rreg(raddr_t a, logic [7:0] e);
    @(posedge clk);
    radr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", rdat, e);
  endtask
  task pchk(logic p, logic [5:0] n);
    tick(8);
    chk("pending", pend, p);
    if (p) chk("irq_num", num, n);
  endtask
  task fetch(vec_src_e s, logic [5:0] n, logic hw, addr_t e);
    @(posedge clk);
    vreq <= 1'b1;
    vsrc <= s;
    vnum <= n;
    vhw <= hw;
    @(posedge clk);
    vreq <= 1'b0;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      #1;
      if (done === 1'b1) break;
    end
    if (i == 100) begin
      n_mismatch++;
      print_verdict();
    end else chk("handler", haddr, e);
  endtask
  // ====
  // scenarios
  task t_fixed;
    // fixed entries lie four bytes apart in source order
    for (int k = 0; k < 9; k++) fetch(vec_src_e'(k), 6'h0, 1'b0, h(20'hfffdc + 20'(4 * k)));
  endtask
  task t_table;
    rreg(REG_VB0, 8'h00);
    wreg(REG_VB0, 8'h40);
    wreg(REG_VB1, 8'h23);
    wreg(REG_VB2, 8'h01);
    rreg(REG_VB2, 8'h01);
    wreg(10'h3ff, 8'hff);
    rreg(10'h3ff, 8'h00);
    @(posedge clk) slow <= 1'b1;
    @(posedge clk) iflag <= 1'b0;
    fetch(VS_SWINT, 6'd63, 1'b0, h(VB + 20'd252));
    fetch(VS_SWINT, 6'd0, 1'b0, h(VB));
    @(posedge clk) brk_e <= 1'b1;
    fetch(VS_BRK, 6'd0, 1'b0, h(VB));
    @(posedge clk) brk_e <= 1'b0;
    @(posedge clk) slow <= 1'b0;
    @(posedge clk) iflag <= 1'b1;
  endtask
  task t_mask;
    wreg(10'h055, 8'h03);
    @(posedge clk) evt <= 32'h1 << 21;
    @(posedge clk) evt <= '0;
    pchk(1'b1, 6'd21);
    chk("irq_level", lvl, 3'd3);
    rreg(10'h055, 8'h0b);
    @(posedge clk) iflag <= 1'b0;
    pchk(1'b0, 6'd0);
    @(posedge clk) iflag <= 1'b1;
    @(posedge clk) thr <= 3'd3;
    pchk(1'b0, 6'd0);
    @(posedge clk) thr <= 3'd2;
    pchk(1'b1, 6'd21);
    fetch(VS_SWINT, 6'd21, 1'b1, h(VB + 20'd84));
    rreg(10'h055, 8'h03);
    pchk(1'b0, 6'd0);
    wreg(10'h055, 8'h00);
    @(posedge clk) thr <= 3'd0;
  endtask
  task pin0(logic v, logic p);
    wreg(10'h05d, 8'h01);
    @(posedge clk) pins[0] <= v;
    pchk(p, 6'd29);
  endtask
  task t_pins;
    pin0(1'b0, 1'b1);
    pin0(1'b1, 1'b0);
    wreg(REG_POL0, 8'h01);
    pin0(1'b0, 1'b0);
    pin0(1'b1, 1'b1);
    wreg(REG_POL0, 8'h02);
    pin0(1'b0, 1'b1);
    pin0(1'b1, 1'b1);
    wreg(10'h05d, 8'h00);
  endtask
  task t_shared;
    wreg(REG_CAUSE, 8'h40);
    wreg(10'h048, 8'h01);
    @(posedge clk) pins[5] <= 1'b0;
    pchk(1'b1, 6'd8);
    wreg(10'h048, 8'h00);
    wreg(10'h049, 8'h01);
    @(posedge clk) evt <= 32'h1 << 9;
    @(posedge clk) evt <= '0;
    pchk(1'b1, 6'd9);
    wreg(10'h049, 8'h00);
    wreg(10'h04d, 8'h01);
    @(posedge clk) key_n <= 1'b0;
    pchk(1'b1, 6'd13);
    @(posedge clk) key_n <= 1'b1;
    tick(8);
    wreg(10'h04d, 8'h00);
    wreg(REG_MODE, 8'h01);
    wreg(10'h04f, 8'h01);
    @(posedge clk) nack <= 1'b1;
    @(posedge clk) nack <= 1'b0;
    pchk(1'b1, 6'd15);
    wreg(10'h04f, 8'h00);
    wreg(10'h050, 8'h01);
    @(posedge clk) ack2 <= 1'b1;
    @(posedge clk) ack2 <= 1'b0;
    pchk(1'b1, 6'd16);
    wreg(10'h050, 8'h00);
  endtask
  task am(addr_t a, logic e);
    @(posedge clk);
    istart <= 1'b1;
    iaddr <= a;
    @(posedge clk);
    istart <= 1'b0;
    #1 chk("addr_match", amreq, e);
  endtask
  task t_match;
    wreg(REG_AM0, 8'h56);
    wreg(REG_AM1, 8'h34);
    wreg(REG_AM2, 8'h02);
    wreg(REG_AM_EN, 8'h01);
    am(20'h23456, 1'b1);
    am(20'h23457, 1'b0);
    wreg(REG_AM_EN, 8'h00);
    am(20'h23456, 1'b0);
  endtask
  // ====
  // main sequence
  initial begin
    {rst, wr, rd, nack, ack2, istart, vreq, vhw, slow, brk_e} = 10'h200;
    {key_n, iflag, thr, pins, evt} = {2'b11, 3'h0, 6'h3f, 32'h0};
    {radr, wdat, iaddr, vnum} = {10'h0, 8'h0, 20'h0, 6'h0};
    vsrc = VS_UND;
    n_mismatch = 0;
    num_checks = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_fixed();
    t_table();
    t_mask();
    t_pins();
    t_shared();
    t_match();
    print_verdict();
  end
endmodule // interrupt_vector_resolver_tb

//--- sim/vec_mem_model.sv
// file: vector memory model answering the resolver's byte reads
// assumes the resolver's clock; one byte per ack, never two acks in a row
`timescale 1ns/100ps
module vec_mem_model (
  input  wire logic        mclk_in,
  input  wire logic        srst_in,
  input  wire logic        slow_in,
  input  wire logic        brk_empty_in,
  input  wire logic        mem_rd_in,
  input  wire logic [19:0] mem_addr_in,
  output logic [7:0]       mem_rdata_out,
  output logic             mem_ack_out
);
  logic tog_ff;
  // ====
  // byte is the low address byte, or ff inside an empty break entry
  always_ff @(posedge mclk_in) begin
    tog_ff <= ~tog_ff & ~srst_in;
    if (srst_in) begin
      mem_ack_out   <= 1'b0;
      mem_rdata_out <= 8'h00;
    end else if (mem_rd_in && !mem_ack_out && (!slow_in || tog_ff)) begin
      mem_ack_out   <= 1'b1;
      mem_rdata_out <= (brk_empty_in && mem_addr_in[19:2] == 18'h3fff9) ? 8'hff
                                                                           : mem_addr_in[7:0];
    end else begin
      mem_ack_out   <= 1'b0;
      mem_rdata_out <= ~mem_rdata_out;
    end
  end
endmodule // vec_mem_model
